// file: hdl/conv_clk_gen.sv
// Gated conversion clock: divider giving a rising-edge enable pulse.
// Assumes run is driven from the sequencer on the same clock.
module conv_clk_gen
(
   // System
   input  wire logic  i_mclk,
   input  wire logic  i_resetn,
   // Sequencer side
   conv_clk_if.gen    cc
);

   logic [sar_seq_pkg::DIV_W-1:0] cnt_r;
   logic [sar_seq_pkg::DIV_W-1:0] div_m1;
   logic [sar_seq_pkg::DIV_W-1:0] half;
   logic                          level_r;

   assign div_m1 = cc.fast ? sar_seq_pkg::DIV_W'(sar_seq_pkg::DIV_FAST - 1)
                           : sar_seq_pkg::DIV_W'(sar_seq_pkg::DIV_SLOW - 1);
   assign half   = div_m1 >> 1;

   // Rising edge of the conversion clock
   assign cc.tick      = cc.run && (cnt_r == div_m1);
   assign cc.clk_level = level_r;

   // Period counter, held at zero while gated off
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         cnt_r <= '0;
      else if (!cc.run || cnt_r == div_m1)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   // Clock level, forced low when gated off
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         level_r <= 1'b0;
      else if (!cc.run)
         level_r <= 1'b0;
      else if (cc.tick)
         level_r <= 1'b1;
      else if (cnt_r == half)
         level_r <= 1'b0;
   end

endmodule : conv_clk_gen

// file: hdl/conv_clk_if.sv
// Carrier between the sequencer and its gated conversion clock source.
// Assumes both ends sit on the same system clock.
interface conv_clk_if;
   logic run;
   logic fast;
   logic tick;
   logic clk_level;

   modport gen
   (
      input  run,
      input  fast,
      output tick,
      output clk_level
   );

   modport user
   (
      output run,
      output fast,
      input  tick,
      input  clk_level
   );
endinterface : conv_clk_if

// file: hdl/sar_adc_seq.sv
// Successive approximation sequencer with complemented parallel output.
// Assumes an external DAC and comparator close the loop, and host logic
// latches the result on the falling edge of busy.
module sar_adc_seq
#(
   parameter int WIDTH = sar_seq_pkg::RES_BITS
)
(
   // System
   input  wire logic             i_mclk,
   input  wire logic             i_resetn,
   // Conversion control
   input  wire logic             i_convert_start,
   input  wire logic             i_short_cycle_n,
   input  wire logic             i_fast_rate,
   // Comparator and feedback DAC
   input  wire logic             i_comp_keep,
   output logic      [WIDTH-1:0] o_dac_code,
   // Status and result
   output logic                  o_busy,
   output logic                  o_conv_clk,
   output logic      [WIDTH-1:0] o_data_n
);

   localparam int IDX_W = $clog2(WIDTH + 1);

   // Refuse builds that the counters below cannot serve
   if (WIDTH < sar_seq_pkg::MIN_RES_BITS || WIDTH > sar_seq_pkg::RES_BITS)
   begin : g_bad_width
      $error("sar_adc_seq: WIDTH out of range");
   end

   if (sar_seq_pkg::SETTLE_CYC < 1
       || sar_seq_pkg::SETTLE_CYC >= (1 << sar_seq_pkg::SETTLE_W))
   begin : g_bad_settle
      $error("sar_adc_seq: settle count does not fit its counter");
   end

   if (sar_seq_pkg::DIV_FAST < 2
       || sar_seq_pkg::DIV_SLOW > (1 << sar_seq_pkg::DIV_W))
   begin : g_bad_div
      $error("sar_adc_seq: clock divider does not fit its counter");
   end

   conv_clk_if cc ();

   conv_clk_gen u_clk
   (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .cc       (cc.gen)
   );

   sar_seq_pkg::seq_state_t           state_r;
   logic                              start_d_r;
   logic                              start_fall;
   logic [IDX_W-1:0]                  idx_r;
   logic [sar_seq_pkg::SETTLE_W-1:0]  settle_r;
   logic [WIDTH-1:0]                  sar_r;
   logic [WIDTH-1:0]                  sar_nxt;
   logic [WIDTH-1:0]                  data_n_r;
   logic                              busy_r;
   logic                              decide;
   logic                              last_bit;
   logic                              stop_req;
   logic                              load;
   logic                              fast_r;

   assign start_fall = start_d_r && !i_convert_start;

   assign cc.run     = (state_r == sar_seq_pkg::ST_RUN);
   assign cc.fast    = fast_r;
   assign o_conv_clk = cc.clk_level;

   assign decide   = cc.tick && (idx_r != '0);
   assign last_bit = decide && (idx_r == IDX_W'(WIDTH));
   // stop pin fed from bit n+1
   assign stop_req = !i_short_cycle_n && (idx_r > IDX_W'(1));
   // Result moves at start or on a decision edge
   assign load     = start_fall || decide;

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         start_d_r <= 1'b0;
      else
         start_d_r <= i_convert_start;
   end

   // rate held steady for a whole conversion
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         fast_r <= 1'b0;
      else if (start_fall)
         fast_r <= i_fast_rate;
   end

   // keep or reject, trial next bit
   for (genvar b = 0; b < WIDTH; b++)
   begin : g_bit
      logic decide_here;
      logic trial_here;
      logic bit_nxt;

      assign decide_here = decide && (idx_r == IDX_W'(WIDTH - b));
      assign trial_here  = decide && (idx_r == IDX_W'(WIDTH - 1 - b));

      always_comb
      begin
         if (start_fall)
            bit_nxt = (b == WIDTH - 1);
         else if (decide_here)
            bit_nxt = sar_r[b] && i_comp_keep;
         else if (trial_here)
            bit_nxt = 1'b1;
         else
            bit_nxt = sar_r[b];
      end

      assign sar_nxt[b] = bit_nxt;
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         sar_r <= '0;
      else if (load)
         sar_r <= sar_nxt;
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         data_n_r <= '1;
      else if (load)
         data_n_r <= ~sar_nxt;
   end

   // Tick index: 0 before first edge, then decisions 1..WIDTH
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         idx_r <= '0;
      else if (start_fall)
         idx_r <= '0;
      else if (cc.tick && idx_r != IDX_W'(WIDTH))
         idx_r <= idx_r + 1'b1;
   end

   // Sequencer
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         state_r <= sar_seq_pkg::ST_IDLE;
      else if (start_fall)
         state_r <= sar_seq_pkg::ST_RUN;
      else
      begin
         case (state_r)
            sar_seq_pkg::ST_IDLE:
               state_r <= sar_seq_pkg::ST_IDLE;
            sar_seq_pkg::ST_RUN:
               if (last_bit || stop_req)
                  state_r <= sar_seq_pkg::ST_SETTLE;
            sar_seq_pkg::ST_SETTLE:
               if (settle_r == sar_seq_pkg::SETTLE_W'(1))
                  state_r <= sar_seq_pkg::ST_IDLE;
            default:
               state_r <= sar_seq_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         settle_r <= '0;
      else if (state_r != sar_seq_pkg::ST_SETTLE)
         settle_r <= sar_seq_pkg::SETTLE_W'(sar_seq_pkg::SETTLE_CYC);
      else if (settle_r != '0)
         settle_r <= settle_r - 1'b1;
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         busy_r <= 1'b0;
      else if (start_fall)
         busy_r <= 1'b1;
      else if (state_r == sar_seq_pkg::ST_SETTLE
               && settle_r == sar_seq_pkg::SETTLE_W'(1))
         busy_r <= 1'b0;
   end

   assign o_busy     = busy_r;
   assign o_data_n   = data_n_r;
   assign o_dac_code = sar_r;

endmodule : sar_adc_seq

// file: hdl/sar_seq_pkg.sv
// Shared constants and types for the successive approximation sequencer.
// Assumes a 100 MHz system clock driving all logic.
package sar_seq_pkg;

   // System clock rate
   localparam int SYS_CLK_KHZ    = 100000;
   // Nominal conversion clock rates, slow and fast
   localparam int CONV_SLOW_KHZ  = 1040;
   localparam int CONV_FAST_KHZ  = 1750;
   // Conversion clock period in system cycles
   localparam int DIV_SLOW       = SYS_CLK_KHZ / CONV_SLOW_KHZ;
   localparam int DIV_FAST       = SYS_CLK_KHZ / CONV_FAST_KHZ;
   localparam int DIV_W          = 8;

   // Result width and smallest supported WIDTH parameter
   localparam int RES_BITS       = 16;
   localparam int MIN_RES_BITS   = 8;

   // Data settled margin before busy falls
   localparam int SETTLE_NS      = 20;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int SETTLE_W       = 3;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_SETTLE
   } seq_state_t;

endpackage : sar_seq_pkg

// file: tb/sar_adc_seq_sva.sv
// Checker on the sequencer ports.
// Assumes one clock and an active-low asynchronous reset.
module sar_adc_seq_sva #(parameter int WIDTH = 16)
(
   // System
   input wire logic             i_mclk,
   input wire logic             i_resetn,
   // Watched
   input wire logic             i_convert_start,
   input wire logic             i_short_cycle_n,
   input wire logic [WIDTH-1:0] o_dac_code,
   input wire logic             o_busy,
   input wire logic             o_conv_clk,
   input wire logic [WIDTH-1:0] o_data_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   localparam logic [WIDTH-1:0] FIRST = {1'b0, {(WIDTH-1){1'b1}}};
   localparam int LIM = 1710;
   int busy_cyc_r;
   always_ff @(posedge i_mclk or negedge i_resetn)
      if (!i_resetn)
         busy_cyc_r <= 0;
      else
         busy_cyc_r <= o_busy ? busy_cyc_r + 1 : 0;
   property p_start;
      $fell(i_convert_start) |=> o_busy && o_data_n == FIRST
         && o_dac_code == ~FIRST;
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_neg; o_busy |-> o_data_n == ~o_dac_code; endproperty
   a_neg: assert property (p_neg) else $error("bad polarity");
   property p_settle; $fell(o_busy) |-> o_data_n == $past(o_data_n, 2);
   endproperty
   a_settle: assert property (p_settle) else $error("late data");
   property p_edge;
      o_busy && $past(o_busy) && $changed(o_data_n) |-> ##[0:1]
         $rose(o_conv_clk);
   endproperty
   a_edge: assert property (p_edge) else $error("data off edge");
   property p_idle; !o_busy && !$past(o_busy) |-> !o_conv_clk; endproperty
   a_idle: assert property (p_idle) else $error("clock not low");
   property p_short; o_busy && !i_short_cycle_n |-> ##[1:4] !o_busy;
   endproperty
   a_short: assert property (p_short) else $error("no early stop");
   property p_hold;
      !o_busy && !$fell(i_convert_start) |=> $stable(o_data_n);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_time; o_busy |-> busy_cyc_r < LIM; endproperty
   a_time: assert property (p_time) else $error("too long");
   c_full: cover property ($fell(o_busy) && i_short_cycle_n);
   c_short: cover property ($fell(o_busy) && !i_short_cycle_n);
   c_start: cover property ($fell(i_convert_start));
endmodule : sar_adc_seq_sva

bind sar_adc_seq sar_adc_seq_sva #(.WIDTH(WIDTH)) chk (.i_mclk(i_mclk),
   .i_resetn(i_resetn), .i_convert_start(i_convert_start),
   .i_short_cycle_n(i_short_cycle_n), .o_dac_code(o_dac_code),
   .o_busy(o_busy), .o_conv_clk(o_conv_clk), .o_data_n(o_data_n));

// file: tb/sar_host_model.sv
// Host side: comparator stand-in and result latch.
// Assumes the sequencer ports of a 16-bit build.
module sar_host_model
(
   // From sequencer and bench
   input  wire logic        i_busy,
   input  wire logic [15:0] i_dac_code,
   input  wire logic [15:0] i_data_n,
   input  wire logic [15:0] i_target,
   // To sequencer and bench
   output logic             o_comp_keep,
   output logic      [15:0] o_latched_n,
   output logic      [15:0] o_twos_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Keep trial while input is not below the DAC
   assign o_comp_keep = i_dac_code <= i_target;
   always @(negedge i_busy) o_latched_n = i_data_n;
   assign o_twos_n = {~o_latched_n[15], o_latched_n[14:0]};
endmodule : sar_host_model

// file: tb/test_sar_adc_output_short_cycle.sv
// Bench: conversions at both rates and short-cycle widths 8, 10, 12, 13, 14 and 15.
// Assumes the host model closes the comparator loop.
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
   miscompares++; $display("unexpected %0t %h %h", $time, a, b); end end
module test_sar_adc_output_short_cycle;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, resetn = 0, start = 0, fast = 0, keep, busy, cclk;
   logic [15:0] dac, data_n, latched_n, twos_n, target = 16'h0000;
   int          sc_bits = 16, miscompares = 0, n_compared = 0, cyc = 0;
   int          len;
   localparam int DIV_S = sar_seq_pkg::DIV_SLOW;
   localparam int DIV_F = sar_seq_pkg::DIV_FAST;
   wire logic   short_n = (sc_bits >= 16) ? 1'b1 : data_n[15 - sc_bits];
   always #5 mclk = ~mclk;
   sar_adc_seq dut (.i_mclk(mclk), .i_resetn(resetn),
      .i_convert_start(start), .i_short_cycle_n(short_n),
      .i_fast_rate(fast), .i_comp_keep(keep), .o_dac_code(dac),
      .o_busy(busy), .o_conv_clk(cclk), .o_data_n(data_n));
   sar_host_model host (.i_busy(busy), .i_dac_code(dac), .i_data_n(data_n),
      .i_target(target), .o_comp_keep(keep), .o_latched_n(latched_n),
      .o_twos_n(twos_n));
   task automatic stop_test();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         miscompares++;
         stop_test();
      end
   end
   task automatic convert(input logic [15:0] t, input logic f, input int n);
      @(negedge mclk);
      target = t;
      fast = f;
      sc_bits = n;
      start = 1;
      @(negedge mclk);
      start = 0;
      len = 0;
      @(negedge mclk);
      while (busy && len < 2000)
      begin
         @(negedge mclk);
         len++;
      end
   endtask : convert
   task automatic t_full_slow();
      convert(16'h6779, 1'b0, 16);
      `CHK(latched_n, ~16'h6779)
      `CHK(len >= 17 * DIV_S && len <= 17 * DIV_S + 4, 1'b1)
      repeat (50) @(negedge mclk);
      `CHK({data_n, cclk}, {latched_n, 1'b0})
      $display("full slow done");
   endtask : t_full_slow
   task automatic t_bipolar_fast();
      convert(16'h8000, 1'b1, 16);
      `CHK(latched_n, 16'h7FFF)
      `CHK(twos_n, 16'hFFFF)
      `CHK(len >= 17 * DIV_F && len <= 1000, 1'b1)
      $display("bipolar fast done");
   endtask : t_bipolar_fast
   task automatic t_short();
      int          w[6] = '{8, 10, 12, 13, 14, 15};
      logic [15:0] exp;
      foreach (w[i])
      begin
         convert(16'hA5C3, 1'b1, w[i]);
         exp = ~((16'hA5C3 & ~(16'hFFFF >> w[i])) | (16'h8000 >> w[i]));
         `CHK(latched_n, exp)
         `CHK(len >= w[i] * DIV_F && len <= (w[i] + 1) * DIV_F + 5, 1'b1)
      end
      $display("short cycle done");
   endtask : t_short
   initial
   begin
      repeat (20) @(negedge mclk);
      resetn = 1;
      repeat (2) @(negedge mclk);
      t_full_slow();
      t_bipolar_fast();
      t_short();
      stop_test();
   end
endmodule : test_sar_adc_output_short_cycle
